//--- design/srw_supervisor.sv
// Contract
// - Hold reset after supply recovers
// - Reset asserted while supply low
// - Manual input low forces reset
// - Debounce manual input, hold pulse
// - Manual hold starts on release
// - Reset within 5 us of press
// - No strobe edge in period resets
// - Watchdog counts only when reset inactive
// - Strobe edge restarts watchdog count
// - Expiry gives hold pulse, then restarts
// - Floating strobe disables watchdog
// - Probe low 7/8, high 1/8
// - Probing repeats every period, even when driven firmly; regular host strobes restart the count before the probe phase
// - Own probe edges never service watchdog
// - Manual input pulled up internally
// - Reset polarity is build parameter
//
// Purpose: Processor supervisor with supply, manual and watchdog reset
// Assumes: Supply comparator is a digital level, 100 MHz clk_sys
// Notes:   Strobe pin has in/out/oe; pull-up is pad level
`timescale 1ns/10ps
`default_nettype none
`include "srw_params.svh"
module srw_supervisor
  import srw_pkg::*;
#(
  parameter logic                 RESET_ACTIVE_HIGH = 1'b0,
  parameter logic [`SRW_CNT_W-1:0] HOLD_TICKS =
    `SRW_CNT_W'(`SRW_HOLD_CYCLES),
  parameter logic [`SRW_CNT_W-1:0] WD_TICKS =
    `SRW_CNT_W'(`SRW_WD_CYCLES),
  parameter logic [7:0]           DEB_TICKS = 8'(`SRW_DEB_CYCLES)
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic supplyLow,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_strobe_in,
  output var  logic strobeOut,
  output var  logic strobeOe,
  output var  logic sysResetOut,
  output var  logic watchdog_expired_out
);
  logic          supplyLowS;
  logic          manualNS;
  logic          strobeS;
  logic          strobePrev_q;
  logic [7:0]    debCnt_q;
  logic          manualHeld_q;
  logic [`SRW_CNT_W-1:0] holdCnt_q;
  logic [`SRW_CNT_W-1:0] wdCnt_q;
  srw_state_type state_q;
  srw_state_type state_d;
  logic          strobeOut_q;
  logic          strobeOe_q;
  logic          floating_q;
  logic          probeHigh_q;
  // Probe flag delayed past the synchroniser latency
  logic [5:0]    probeDly_q;
  logic          rstOut_q;
  logic          wdo_q;

  // Pad pull-up keeps the undriven manual input high
  srw_sync #(.RESET_VAL(1'b0)) u_sync_supply (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (supplyLow),
    .dout    (supplyLowS)
  );
  srw_sync #(.RESET_VAL(1'b1)) u_sync_manual (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (manual_reset_n),
    .dout    (manualNS)
  );
  srw_sync #(.RESET_VAL(1'b0)) u_sync_strobe (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (watchdog_strobe_in),
    .dout    (strobeS)
  );

  wire strobeEdge  = (strobeS != strobePrev_q);
  // Edge caused by own probing is not a host strobe
  wire hostEdge    = strobeEdge && !probeHigh_q && (probeDly_q == 6'h00);
  wire debDone     = (debCnt_q >= DEB_TICKS);
  wire manualAct   = manualHeld_q;
  wire anyHold     = supplyLowS || manualAct;
  wire holdDone    = (holdCnt_q >= HOLD_TICKS - 1'b1);
  wire wdExpire    = (wdCnt_q >= WD_TICKS - 1'b1) && !floating_q;
  wire [`SRW_CNT_W-1:0] probeStart = WD_TICKS - (WD_TICKS >> 3);
  wire probePhase  = (wdCnt_q >= probeStart);
  wire wdPeriodEnd = (wdCnt_q >= WD_TICKS - 1'b1);

  // Debounce: press accepted after stable low for DEB_TICKS
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      debCnt_q     <= 8'h00;
      manualHeld_q <= 1'b0;
    end else if (!manualNS) begin
      if (!debDone) begin
        debCnt_q <= debCnt_q + 8'h01;
      end
      manualHeld_q <= manualHeld_q || debDone;
    end else begin
      debCnt_q     <= 8'h00;
      manualHeld_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SRW_ACT: begin
        if (!anyHold) begin
          state_d = SRW_HOLD;
        end
      end
      SRW_HOLD: begin
        if (anyHold) begin
          state_d = SRW_ACT;
        end else if (holdDone) begin
          state_d = SRW_RUN;
        end
      end
      SRW_RUN: begin
        if (anyHold) begin
          state_d = SRW_ACT;
        end else if (wdExpire && !hostEdge) begin
          state_d = SRW_HOLD;
        end
      end
      default: state_d = SRW_ACT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= SRW_ACT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || state_q != SRW_HOLD) begin
      holdCnt_q <= '0;
    end else begin
      holdCnt_q <= holdCnt_q + 1'b1;
    end
  end

  // Watchdog timer, idle while reset asserted
  always_ff @(posedge clk_sys) begin
    if (reset || state_q != SRW_RUN) begin
      wdCnt_q <= '0;
    end else if (hostEdge || wdPeriodEnd) begin
      wdCnt_q <= '0;
    end else begin
      wdCnt_q <= wdCnt_q + 1'b1;
    end
  end

  // Open pin detection: weak drive, pin follows when nobody drives it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strobePrev_q <= 1'b0;
      probeHigh_q  <= 1'b0;
      probeDly_q   <= 6'h00;
      floating_q   <= 1'b0;
      strobeOut_q  <= 1'b0;
      strobeOe_q   <= 1'b0;
    end else begin
      strobePrev_q <= strobeS;
      strobeOe_q   <= (state_q == SRW_RUN);
      strobeOut_q  <= probePhase;
      probeHigh_q  <= probePhase;
      probeDly_q   <= {probeDly_q[4:0], probeHigh_q};
      if (hostEdge) begin
        floating_q <= 1'b0;
      end else if (probePhase && strobeS) begin
        floating_q <= 1'b1;
      end else if (!probePhase && wdCnt_q != '0 && strobeS) begin
        floating_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rstOut_q <= RESET_ACTIVE_HIGH;
      wdo_q    <= 1'b0;
    end else begin
      rstOut_q <= (state_d != SRW_RUN) ~^ RESET_ACTIVE_HIGH;
      if (state_q == SRW_RUN && state_d == SRW_HOLD) begin
        wdo_q <= 1'b1;
      end else if (state_d == SRW_RUN) begin
        wdo_q <= 1'b0;
      end
    end
  end

  assign sysResetOut          = rstOut_q;
  assign watchdog_expired_out = wdo_q;
  assign strobeOut            = strobeOut_q;
  assign strobeOe             = strobeOe_q;

  property p_supply_reset;
    @(posedge clk_sys) disable iff (reset)
      supplyLowS |=> ##1 (sysResetOut == RESET_ACTIVE_HIGH);
  endproperty
  a_supply_reset: assert property (p_supply_reset)
    else $error("reset not asserted while supply low");

  property p_manual_fast;
    @(posedge clk_sys) disable iff (reset)
      $fell(manualNS) ##1 !manualNS [*8]
      |-> ##[1:490] (sysResetOut == RESET_ACTIVE_HIGH);
  endproperty
  a_manual_fast: assert property (p_manual_fast)
    else $error("manual reset too slow");

  property p_hold_release;
    @(posedge clk_sys) disable iff (reset)
      (state_q == SRW_HOLD && state_d == SRW_RUN)
      |-> (holdCnt_q == HOLD_TICKS - 1'b1);
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("hold time wrong at release");

  property p_wd_idle;
    @(posedge clk_sys) disable iff (reset)
      (state_q != SRW_RUN) |=> (wdCnt_q == '0);
  endproperty
  a_wd_idle: assert property (p_wd_idle)
    else $error("watchdog counted during reset");

  property p_wd_restart;
    @(posedge clk_sys) disable iff (reset)
      (state_q == SRW_RUN && hostEdge && !anyHold) |=> (wdCnt_q == '0);
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("strobe edge did not restart watchdog");

  property p_expire;
    @(posedge clk_sys) disable iff (reset)
      (state_q == SRW_RUN && wdExpire && !hostEdge && !anyHold)
      |=> (state_q == SRW_HOLD) ##0 (sysResetOut == RESET_ACTIVE_HIGH);
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not assert reset");

  property p_manual_held;
    @(posedge clk_sys) disable iff (reset)
      manualHeld_q |=> (state_q != SRW_RUN);
  endproperty
  a_manual_held: assert property (p_manual_held)
    else $error("reset released during manual press");

  property p_probe_low;
    @(posedge clk_sys) disable iff (reset)
      (state_q == SRW_RUN && !probePhase) |=> !strobeOut;
  endproperty
  a_probe_low: assert property (p_probe_low)
    else $error("probe drove high in low phase");

  property p_float_no_expire;
    @(posedge clk_sys) disable iff (reset)
      (floating_q && state_q == SRW_RUN && !anyHold) |=> (state_q == SRW_RUN);
  endproperty
  a_float_no_expire: assert property (p_float_no_expire)
    else $error("floating strobe caused watchdog reset");
endmodule // srw_supervisor
`default_nettype wire

//--- design/srw_params.svh
// Purpose: Timing constants for the supervisor reset watchdog
// Assumes: 100 MHz clk_sys, 10 ns period
// Notes:   Times kept in their own unit, cycles derived
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH

`define SRW_CLK_PERIOD_NS   10
`define SRW_HOLD_MS         140
`define SRW_HOLD_CYCLES     ((`SRW_HOLD_MS * 1000000) / `SRW_CLK_PERIOD_NS)
`define SRW_WD_PERIOD_MS    1600
`define SRW_WD_CYCLES       ((`SRW_WD_PERIOD_MS * 1000000) / `SRW_CLK_PERIOD_NS)
`define SRW_DLY_US          5
`define SRW_DLY_CYCLES      ((`SRW_DLY_US * 1000) / `SRW_CLK_PERIOD_NS)
`define SRW_DEB_US          1
`define SRW_DEB_CYCLES      ((`SRW_DEB_US * 1000) / `SRW_CLK_PERIOD_NS)
`define SRW_CNT_W           28

`endif

//--- design/srw_pkg.sv
// Purpose: Types for the supervisor reset watchdog
// Assumes: Nothing
// Notes:   Gray coded states
package srw_pkg;
  typedef enum logic [1:0] {
    SRW_RUN  = 2'b00,
    SRW_HOLD = 2'b01,
    SRW_ACT  = 2'b11
  } srw_state_type;
endpackage

//--- design/srw_sync.sv
// Purpose: Three flop synchroniser with agreement filter
// Assumes: Input asynchronous to clk_sys
// Notes:   Output changes once flops two and three agree
`timescale 1ns/10ps
`default_nettype none
module srw_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic din,
  output var  logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q  <= RESET_VAL;
      s2_q  <= RESET_VAL;
      s3_q  <= RESET_VAL;
      out_q <= RESET_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign dout = out_q;
endmodule // srw_sync
`default_nettype wire

//--- test/srw_host_model.sv
// Purpose: Host side of the watchdog strobe pin
// Assumes: Pin level is resolved here for the design
// Notes:   Mode 0 pulses, 1 holds low, 2 leaves the pin open
`timescale 1ns/10ps
`default_nettype none
module srw_host_model #(
  parameter int PULSE_EVERY = 800
) (
  input  wire logic       clk_sys,
  input  wire logic [1:0] mode,
  input  wire logic       strobeOut,
  input  wire logic       strobeOe,
  output wire logic       pin
);
  logic hostVal;
  logic junk_q = 1'b0;
  int   cnt_q  = 0;
  always @(posedge clk_sys) begin
    cnt_q  <= (cnt_q >= PULSE_EVERY - 1) ? 0 : cnt_q + 1;
    junk_q <= ~pin;
  end
  // Mostly low, short high pulse
  assign hostVal = (mode == 2'h0) && (cnt_q < 8);
  // Open pin wanders unless the probe drives it
  assign pin = (mode != 2'h2) ? hostVal :
               strobeOe ? strobeOut : junk_q;
endmodule // srw_host_model
`default_nettype wire

//--- test/srw_supervisor_test.sv
// Purpose: Self-checking bench for the supervisor
// Assumes: Short hold and period parameters
// Notes:   Reset output active low
`timescale 1ns/10ps
`default_nettype none
module srw_supervisor_test
  import srw_pkg::*;
;
  localparam int HOLD = 200;
  localparam int WD   = 1600;
  logic       clk_sys        = 1'b0;
  logic       reset          = 1'b1;
  logic       supplyLow      = 1'b1;
  logic       manual_reset_n = 1'b1;
  logic [1:0] mode           = 2'h0;
  wire logic  strobePin;
  wire logic  strobeOut;
  wire logic  strobeOe;
  wire logic  sysResetOut;
  wire logic  wdExp;
  int         n_fail         = 0;
  int         comparisons    = 0;
  int         t;
  int         hi;
  int         a;

  always #5 clk_sys = ~clk_sys;

  srw_supervisor #(.RESET_ACTIVE_HIGH(1'b0), .HOLD_TICKS(28'h00000c8),
    .WD_TICKS(28'h0000640), .DEB_TICKS(8'h04)) dut (
    .clk_sys(clk_sys), .reset(reset), .supplyLow(supplyLow),
    .manual_reset_n(manual_reset_n), .watchdog_strobe_in(strobePin),
    .strobeOut(strobeOut), .strobeOe(strobeOe),
    .sysResetOut(sysResetOut), .watchdog_expired_out(wdExp));

  srw_host_model #(.PULSE_EVERY(800)) host (.clk_sys(clk_sys),
    .mode(mode), .strobeOut(strobeOut), .strobeOe(strobeOe),
    .pin(strobePin));

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi_lim,
                         input string msg);
    comparisons++;
    if (got < lo || got > hi_lim) begin
      n_fail++;
      $display("mismatch at %0t: %s got %0d", $time, msg, got);
    end
  endtask

  // Counts probe-high and reset-asserted cycles
  task automatic run(input int n, output int nHi, output int nAs);
    nHi = 0;
    nAs = 0;
    repeat (n) begin
      step();
      if (strobeOe === 1'b1 && strobeOut === 1'b1) nHi++;
      if (sysResetOut === 1'b0) nAs++;
    end
  endtask

  task automatic wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (sysResetOut !== lvl && n < lim) begin
      step();
      n++;
    end
  endtask

  task automatic t_power();
    run(300, hi, a);
    chk_rng(a, 300, 300, "reset during low supply");
    supplyLow = 1'b0;
    wait_rst(1'b1, HOLD + 50, t);
    chk_rng(t, HOLD, HOLD + 15, "hold after supply");
    $display("test power done");
  endtask

  task automatic t_manual();
    manual_reset_n = 1'b0;
    wait_rst(1'b0, 500, t);
    chk_rng(t, 1, 499, "manual to reset delay");
    run(1000, hi, a);
    chk_rng(a, 1000, 1000, "reset while pressed");
    manual_reset_n = 1'b1;
    wait_rst(1'b1, HOLD + 50, t);
    chk_rng(t, HOLD, HOLD + 15, "hold after release");
    chk(sysResetOut, 1'b1, "released after hold");
    $display("test manual done");
  endtask

  task automatic t_strobe();
    run(4 * WD, hi, a);
    chk_rng(a, 0, 0, "reset despite strobes");
    $display("test strobe done");
  endtask

  task automatic t_expire();
    mode = 2'h1;
    wait_rst(1'b0, WD + 900, t);
    chk_rng(t, WD - 810, WD + 15, "first expiry");
    chk(wdExp, 1'b1, "expiry flag");
    wait_rst(1'b1, HOLD + 50, t);
    chk_rng(t, HOLD - 5, HOLD + 5, "expiry hold");
    wait_rst(1'b0, WD + 50, t);
    chk_rng(t, WD - 5, WD + 5, "period from release");
    $display("test expire done");
  endtask

  task automatic t_float();
    mode = 2'h2;
    wait_rst(1'b1, HOLD + 50, t);
    run(3 * WD, hi, a);
    chk_rng(a, 0, 0, "reset with open pin");
    chk_rng(hi, 3 * WD / 8 - 20, 3 * WD / 8 + 20, "probe high");
    mode = 2'h0;
    run(2 * WD, hi, a);
    chk_rng(a, 0, 0, "reset after driving again");
    $display("test float done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    $display("mismatch at %0t: run too long", $time);
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_power();
    t_manual();
    t_strobe();
    t_expire();
    t_float();
    wrap_up();
  end
endmodule // srw_supervisor_test
`default_nettype wire
